// ===== rtl/qsc_pkg.sv
package qsc_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int NUM_CH = 4;
  localparam int SPAN_W = 3;
  localparam int SPAN_REG_W = NUM_CH * SPAN_W;
  localparam logic [SPAN_REG_W-1:0] SPAN_RESET = 12'hfff;
  localparam logic [SPAN_W-1:0] SPAN_DISABLED = 3'h0;
  localparam logic [SPAN_REG_W-1:0] SPAN_IGNORED_WORD = 12'h000;
  // Longest conversion: per-channel slope minus a fixed offset
  localparam int CONV_PER_CH_NS = 525;
  localparam int CONV_OFFSET_NS = 20;
  localparam int INIT_TIME_MS = 10;
  localparam int INIT_CYCLES = (INIT_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int GRST_CYCLES = 16;
  localparam int CONV_CNT_W = 8;
  localparam int TIMER_W = 20;

  typedef enum logic [2:0] {
    QSC_GRST,
    QSC_INIT,
    QSC_NAP,
    QSC_CONV,
    QSC_PD
  } qsc_state_t;

  // Longest time rounds down; an empty channel set still takes one cycle
  function automatic logic [CONV_CNT_W-1:0] conv_cycles(input logic [2:0] n);
    int t;
    t = (CONV_PER_CH_NS * int'(n) - CONV_OFFSET_NS) / CLK_PERIOD_NS;
    if (n == 3'h0 || t < 1) begin
      t = 1;
    end
    return t[CONV_CNT_W-1:0];
  endfunction : conv_cycles
endpackage : qsc_pkg

// ===== rtl/qsc_sync_edge.sv
`timescale 1ns/1ps
module qsc_sync_edge #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;
  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_stable;
  logic [WIDTH-1:0] next_prev;

  initial begin
    if (WIDTH < 1) begin
      $error("qsc_sync_edge: WIDTH must be at least 1");
    end
  end

  always_comb begin
    next_meta = pin;
    next_stable = meta;
    next_prev = stable;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      stable <= '0;
      prev <= '0;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      prev <= next_prev;
    end
  end

  assign level = stable;
  assign rise = stable & ~prev;
endmodule : qsc_sync_edge

// ===== rtl/qsc_down_counter.sv
`timescale 1ns/1ps
module qsc_down_counter #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] value,
  output logic zero
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  initial begin
    if (WIDTH < 2) begin
      $error("qsc_down_counter: WIDTH must be at least 2");
    end
  end

  always_comb begin
    if (load) begin
      next_count = value;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end else begin
      next_count = count;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign zero = (count == '0);
endmodule : qsc_down_counter

// ===== rtl/qsc_conv_ctrl.sv
// Operation
// R1 - Start rising edge holds all channels together and begins conversion.
// R2 - A started conversion runs to its end; only reset stops it.
// R3 - Busy rises at conversion start and stays high until it ends.
// R4 - Host lowers start 40-60ns after rising, or after busy falls.
// R5 - Start low at least 390ns after busy falls; sets acquisition.
// R6 - Conversion lasts at most 525 times channel count minus 20ns.
// R7 - Power-down high powers down and ignores start edges.
// R8 - Power-down during conversion takes effect after conversion completes.
// R9 - Host waits 10ms, or 200ms with reference buffer, after power-down.
// R10 - Supply monitor resets at power-up and below 2V, then reinitialises.
// R11 - Host waits 10ms after any power-on reset before converting.
// R12 - Second power-down rise without conversion between triggers global reset.
// R13 - Global reset ends by itself on an internal timer.
// R14 - Global reset clears output data and sets all spans to code 7.
// R15 - Global reset during conversion halts that conversion at once.
// R16 - Global reset leaves ordinary power-down behaviour unchanged.
// R17 - Nap after each conversion; full power on next start edge.
// R18 - Interface select pin chooses CMOS or LVDS serial interface.
// R19 - CMOS mode keeps all four lanes live; host reads one to four. Lanes are held off during rst_n reset.
// R20 - Data window opens 10ms after reset and when busy falls.
// R21 - Span code 000 disables channel; next conversion time shrinks.
// R22 - Twelve-bit span register resets to all ones.
// R23 - Any conversion start discards a pending first power-down rise.
`timescale 1ns/1ps
module qsc_conv_ctrl #(
  parameter int INIT_CYCLES = qsc_pkg::INIT_CYCLES,
  parameter int GRST_CYCLES = qsc_pkg::GRST_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic conversion_start_input,
  input wire logic power_down_input,
  input wire logic supply_ok,
  input wire logic lvds_select,
  input wire logic span_word_valid,
  input wire logic [qsc_pkg::SPAN_REG_W-1:0] span_word,
  output logic busy,
  output logic sample_hold,
  output logic powered_down,
  output logic napping,
  output logic global_reset_active,
  output logic clear_output_data,
  output logic window_open,
  output logic init_done,
  output logic lvds_mode,
  output logic [qsc_pkg::NUM_CH-1:0] serial_out_lane_enable,
  output logic [qsc_pkg::SPAN_REG_W-1:0] span_select,
  output logic [qsc_pkg::NUM_CH-1:0] channel_enable
);
  localparam int NC = qsc_pkg::NUM_CH;
  localparam int SW = qsc_pkg::SPAN_W;

  initial begin
    if (INIT_CYCLES < 1 || INIT_CYCLES >= (1 << qsc_pkg::TIMER_W)) begin
      $error("qsc_conv_ctrl: INIT_CYCLES out of range");
    end
    if (GRST_CYCLES < 1 || GRST_CYCLES >= (1 << qsc_pkg::TIMER_W)) begin
      $error("qsc_conv_ctrl: GRST_CYCLES out of range");
    end
  end

  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic lvds_level;
  logic start_rise;
  logic pd_level;
  logic pd_rise;
  logic supply_good;

  qsc_sync_edge #(.WIDTH(3)) u_sync_ctl (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin({supply_ok, power_down_input, conversion_start_input}),
    .level(pin_level),
    .rise(pin_rise)
  );

  qsc_sync_edge #(.WIDTH(1)) u_sync_sel (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin(lvds_select),
    .level(lvds_level),
    .rise()
  );

  assign start_rise = pin_rise[0];
  assign pd_level = pin_level[1];
  assign pd_rise = pin_rise[1];
  assign supply_good = pin_level[2];

  qsc_pkg::qsc_state_t state;
  qsc_pkg::qsc_state_t next_state;
  logic pd_armed;
  logic next_pd_armed;
  logic [qsc_pkg::SPAN_REG_W-1:0] next_span;
  logic next_busy;
  logic next_hold;
  logic next_powered_down;
  logic next_napping;
  logic next_grst;
  logic next_clear;
  logic next_window;
  logic next_init_done;
  logic [NC-1:0] next_chan_en;
  logic [NC-1:0] span_live;
  logic [2:0] live_count;
  logic conv_load;
  logic conv_zero;
  logic timer_load;
  logic [qsc_pkg::TIMER_W-1:0] timer_value;
  logic timer_zero;
  logic start_ok;
  logic grst_fire;

  // R21 channel on unless 000
  genvar ch;
  generate
    for (ch = 0; ch < NC; ch++) begin : g_chan
      assign span_live[ch] = (span_select[ch*SW +: SW] != qsc_pkg::SPAN_DISABLED);
    end
  endgenerate

  always_comb begin
    live_count = 3'h0;
    for (int i = 0; i < NC; i++) begin
      live_count = live_count + {2'h0, channel_enable[i]};
    end
  end

  // R7 starts ignored in power-down
  assign start_ok = start_rise && !pd_level && state == qsc_pkg::QSC_NAP;
  // R12 second rise with armed flag
  assign grst_fire = pd_rise && pd_armed;

  // R6 count from enabled channels
  qsc_down_counter #(.WIDTH(qsc_pkg::CONV_CNT_W)) u_conv_cnt (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(conv_load),
    // Busy stands one cycle past the load, so load one less
    .value(qsc_pkg::conv_cycles(live_count) - 8'h01),
    .zero(conv_zero)
  );

  // R13 self-timed reset and init
  qsc_down_counter #(.WIDTH(qsc_pkg::TIMER_W)) u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(timer_load),
    .value(timer_value),
    .zero(timer_zero)
  );

  always_comb begin
    next_state = state;
    next_pd_armed = pd_armed;
    next_span = span_select;
    next_busy = busy;
    next_hold = sample_hold;
    next_window = window_open;
    next_init_done = init_done;
    next_clear = 1'b0;
    conv_load = 1'b0;
    timer_load = 1'b0;
    timer_value = qsc_pkg::TIMER_W'(INIT_CYCLES);
    // R12 arm on first rise
    if (pd_rise) begin
      next_pd_armed = !pd_armed;
    end
    // R10 supply loss holds reset
    if (!supply_good) begin
      next_state = qsc_pkg::QSC_GRST;
      next_pd_armed = 1'b0;
      next_span = qsc_pkg::SPAN_RESET;
      next_busy = 1'b0;
      next_hold = 1'b0;
      next_window = 1'b0;
      next_init_done = 1'b0;
      next_clear = 1'b1;
      timer_load = 1'b1;
      timer_value = qsc_pkg::TIMER_W'(GRST_CYCLES);
    end else if (grst_fire) begin
      // R15 halt conversion at once
      next_state = qsc_pkg::QSC_GRST;
      next_pd_armed = 1'b0;
      // R14 R22 spans to code 7
      next_span = qsc_pkg::SPAN_RESET;
      next_busy = 1'b0;
      next_hold = 1'b0;
      next_window = 1'b0;
      next_init_done = 1'b0;
      next_clear = 1'b1;
      timer_load = 1'b1;
      timer_value = qsc_pkg::TIMER_W'(GRST_CYCLES);
    end else begin
      unique case (state)
        qsc_pkg::QSC_GRST: begin
          next_clear = 1'b1;
          if (timer_zero) begin
            next_state = qsc_pkg::QSC_INIT;
            timer_load = 1'b1;
          end
        end
        qsc_pkg::QSC_INIT: begin
          if (timer_zero) begin
            // R20 window after init
            next_window = 1'b1;
            next_init_done = 1'b1;
            next_state = pd_level ? qsc_pkg::QSC_PD : qsc_pkg::QSC_NAP;
          end
        end
        qsc_pkg::QSC_NAP: begin
          if (pd_level) begin
            next_state = qsc_pkg::QSC_PD;
          end else if (start_ok) begin
            // R1 R3 hold and busy
            next_state = qsc_pkg::QSC_CONV;
            next_busy = 1'b1;
            next_hold = 1'b1;
            next_window = 1'b0;
            // R23 drop pending rise
            next_pd_armed = 1'b0;
            conv_load = 1'b1;
          end
        end
        qsc_pkg::QSC_CONV: begin
          // R2 R8 run to the end
          if (conv_zero) begin
            next_busy = 1'b0;
            next_hold = 1'b0;
            // R20 window on busy fall
            next_window = 1'b1;
            // R17 nap after conversion
            next_state = pd_level ? qsc_pkg::QSC_PD : qsc_pkg::QSC_NAP;
          end
        end
        qsc_pkg::QSC_PD: begin
          // R16 level alone governs power-down
          if (!pd_level) begin
            next_state = qsc_pkg::QSC_NAP;
          end
        end
      endcase
    end
    // Span words taken only inside the window
    if (span_word_valid && next_window && window_open
        && span_word != qsc_pkg::SPAN_IGNORED_WORD) begin
      next_span = span_word;
    end
  end

  always_comb begin
    next_powered_down = (next_state == qsc_pkg::QSC_PD);
    next_napping = (next_state == qsc_pkg::QSC_NAP);
    next_grst = (next_state == qsc_pkg::QSC_GRST);
    // R21 disable on code 000
    for (int i = 0; i < NC; i++) begin
      next_chan_en[i] = (next_span[i*SW +: SW] != qsc_pkg::SPAN_DISABLED);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= qsc_pkg::QSC_GRST;
      pd_armed <= 1'b0;
      span_select <= qsc_pkg::SPAN_RESET;
      busy <= 1'b0;
      sample_hold <= 1'b0;
      powered_down <= 1'b0;
      napping <= 1'b0;
      global_reset_active <= 1'b1;
      clear_output_data <= 1'b1;
      window_open <= 1'b0;
      init_done <= 1'b0;
      channel_enable <= '1;
      lvds_mode <= 1'b0;
      serial_out_lane_enable <= '0;
    end else begin
      state <= next_state;
      pd_armed <= next_pd_armed;
      span_select <= next_span;
      busy <= next_busy;
      sample_hold <= next_hold;
      powered_down <= next_powered_down;
      napping <= next_napping;
      global_reset_active <= next_grst;
      clear_output_data <= next_clear;
      window_open <= next_window;
      init_done <= next_init_done;
      channel_enable <= next_chan_en;
      // R18 interface select
      lvds_mode <= lvds_level;
      // R19 all CMOS lanes live once out of rst_n reset
      serial_out_lane_enable <= lvds_level ? '0 : '1;
    end
  end

  logic unused_live;
  assign unused_live = ^{span_live, pin_rise[2]};
endmodule : qsc_conv_ctrl

// ===== sim/qsc_conv_ctrl_properties.sv
`timescale 1ns/1ps
module qsc_conv_ctrl_checker #(
  parameter int INIT_CYCLES = 20,
  parameter int GRST_CYCLES = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic conversion_start_input,
  input wire logic power_down_input,
  input wire logic busy,
  input wire logic sample_hold,
  input wire logic powered_down,
  input wire logic napping,
  input wire logic global_reset_active,
  input wire logic clear_output_data,
  input wire logic window_open,
  input wire logic init_done,
  input wire logic lvds_mode,
  input wire logic [3:0] serial_out_lane_enable,
  input wire logic [11:0] span_select
);
  localparam int GR_MAX = GRST_CYCLES + 16;
  logic [7:0] busy_len;
  logic [7:0] next_busy_len;

  always_comb begin
    next_busy_len = busy ? busy_len + 8'h01 : 8'h00;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_len <= 8'h00;
    end else begin
      busy_len <= next_busy_len;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_hold_tracks_busy: assert property (busy == sample_hold)
    else $error("sample hold differs from busy");
  a_start_to_busy: assert property ($rose(conversion_start_input) && napping
    && !power_down_input |-> ##[1:6] busy) else $error("start edge not taken");
  a_busy_holds: assert property ($rose(busy) |-> (busy || global_reset_active)[*8])
    else $error("busy dropped early");
  // Four channels at most: 2080ns, 104 cycles high
  a_conv_bound: assert property ($fell(busy) |-> busy_len <= 8'h68)
    else $error("conversion too long");
  a_runs_full: assert property ($fell(busy) && !global_reset_active
    |-> busy_len >= 8'h19) else $error("conversion cut short");
  a_pd_ignores: assert property (powered_down |=> !$rose(busy))
    else $error("start accepted in power down");
  a_busy_awake: assert property (busy |-> !powered_down && !napping)
    else $error("power down or nap during conversion");
  a_fall_to_nap: assert property ($fell(busy) && !power_down_input
    && !global_reset_active |-> napping && window_open) else $error("no nap after conversion");
  a_grst_state: assert property (global_reset_active
    |-> !busy && span_select == 12'hfff && clear_output_data) else $error("reset state wrong");
  a_grst_ends: assert property ($rose(global_reset_active)
    |-> ##[1:GR_MAX] !global_reset_active) else $error("reset never ends");
  a_cmos_lanes: assert property (init_done && !lvds_mode && !$past(lvds_mode)
    && !global_reset_active |-> serial_out_lane_enable == 4'hf) else $error("lanes off");

  c_conv_done: cover property ($fell(busy));
  c_grst: cover property ($rose(global_reset_active));
  c_pd: cover property ($rose(powered_down));
endmodule : qsc_conv_ctrl_checker

bind qsc_conv_ctrl qsc_conv_ctrl_checker #(.INIT_CYCLES(INIT_CYCLES), .GRST_CYCLES(GRST_CYCLES))
  i_qsc_conv_ctrl_checker (.mclk, .rst_n, .conversion_start_input, .power_down_input, .busy,
  .sample_hold, .powered_down, .napping, .global_reset_active, .clear_output_data,
  .window_open, .init_done, .lvds_mode, .serial_out_lane_enable, .span_select);

// ===== sim/qsc_host_model.sv
`timescale 1ns/1ps
module qsc_host_model (
  input wire logic mclk,
  output logic conversion_start_input,
  output logic power_down_input
);
  initial begin
    conversion_start_input = 1'h0;
    power_down_input = 1'h0;
  end
  task automatic convert;
    repeat (20) @(posedge mclk);
    #2 conversion_start_input = 1'h1;
    repeat (3) @(posedge mclk);
    #2 conversion_start_input = 1'h0;
  endtask : convert
  task automatic set_pd(input logic v);
    power_down_input = v;
  endtask : set_pd
endmodule : qsc_host_model

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic mclk, rst_n, conversion_start_input, power_down_input, supply_ok, lvds_select;
  logic span_word_valid, busy, sample_hold, powered_down, napping, global_reset_active;
  logic clear_output_data, window_open, init_done, lvds_mode;
  logic [3:0] serial_out_lane_enable, channel_enable;
  logic [11:0] span_word, span_select;
  int mismatches, samples_checked;
  // Shortened init wait so the run stays brief
  localparam int INIT_SIM = 20;

  qsc_conv_ctrl #(
    .INIT_CYCLES(INIT_SIM)
  ) i_qsc_conv_ctrl (
    .mclk(mclk),
    .rst_n(rst_n),
    .conversion_start_input(conversion_start_input),
    .power_down_input(power_down_input),
    .supply_ok(supply_ok),
    .lvds_select(lvds_select),
    .span_word_valid(span_word_valid),
    .span_word(span_word),
    .busy(busy),
    .sample_hold(sample_hold),
    .powered_down(powered_down),
    .napping(napping),
    .global_reset_active(global_reset_active),
    .clear_output_data(clear_output_data),
    .window_open(window_open),
    .init_done(init_done),
    .lvds_mode(lvds_mode),
    .serial_out_lane_enable(serial_out_lane_enable),
    .span_select(span_select),
    .channel_enable(channel_enable)
  );
  qsc_host_model i_qsc_host_model (
    .mclk(mclk),
    .conversion_start_input(conversion_start_input),
    .power_down_input(power_down_input)
  );

  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wait_for(ref logic sig, input logic v);
    int i;
    for (i = 0; i < 400 && sig !== v; i++) begin
      @(posedge mclk);
      #2;
    end
    check("wait_level", 12'(v), 12'(sig));
  endtask : wait_for

  task automatic conv(input int len, input logic pd_mid);
    int n;
    n = 0;
    fork
      i_qsc_host_model.convert();
      begin
        wait_for(busy, 1'h1);
        i_qsc_host_model.set_pd(pd_mid);
        while (busy === 1'h1 && n < 300) begin
          @(posedge mclk);
          #2 n++;
        end
      end
    join
    check("busy_cycles", 12'(len), 12'(n));
    check("nap_at_end", 12'(!pd_mid), 12'(napping));
    check("window", 12'h001, 12'(window_open));
  endtask : conv

  task automatic pulse_pd;
    i_qsc_host_model.set_pd(1'h1);
    repeat (4) @(posedge mclk);
    #2 i_qsc_host_model.set_pd(1'h0);
    repeat (4) @(posedge mclk);
    #2;
  endtask : pulse_pd

  task automatic load_span(input logic [11:0] w);
    span_word = w;
    span_word_valid = 1'h1;
    @(posedge mclk);
    #2 span_word_valid = 1'h0;
    @(posedge mclk);
    #2;
  endtask : load_span

  task automatic t_reset_values;
    check("span_reset", 12'hfff, span_select);
    check("chan_reset", 12'h00f, 12'(channel_enable));
    wait_for(init_done, 1'h1);
    check("window_init", 12'h001, 12'(window_open));
  endtask : t_reset_values

  task automatic t_conv_full;
    conv(104, 1'h0);
    conv(104, 1'h0);
  endtask : t_conv_full

  task automatic t_span_disable;
    load_span(12'h007);
    check("chan_en", 12'h001, 12'(channel_enable));
    conv(25, 1'h0);
    load_span(12'h000);
    check("span_zero_word", 12'h007, span_select);
  endtask : t_span_disable

  task automatic t_pd_mid;
    conv(25, 1'h1);
    repeat (2) @(posedge mclk);
    #2 check("pd_state", 12'h001, 12'(powered_down));
    i_qsc_host_model.convert();
    repeat (8) @(posedge mclk);
    #2 check("pd_ignore", 12'h000, 12'(busy));
    i_qsc_host_model.set_pd(1'h0);
    conv(25, 1'h0);
  endtask : t_pd_mid

  task automatic t_rearm;
    pulse_pd();
    conv(25, 1'h0);
    pulse_pd();
    check("no_reset", 12'h000, 12'(global_reset_active));
    check("span_kept", 12'h007, span_select);
  endtask : t_rearm

  task automatic t_grst;
    i_qsc_host_model.convert();
    wait_for(busy, 1'h1);
    pulse_pd();
    i_qsc_host_model.set_pd(1'h1);
    repeat (5) @(posedge mclk);
    #2 check("grst_on", 12'h001, 12'(global_reset_active));
    check("grst_halt", 12'h000, 12'(busy));
    check("grst_span", 12'hfff, span_select);
    check("grst_clear", 12'h001, 12'(clear_output_data));
    wait_for(global_reset_active, 1'h0);
    wait_for(init_done, 1'h1);
    repeat (3) @(posedge mclk);
    #2 check("grst_pd", 12'h001, 12'(powered_down));
    i_qsc_host_model.set_pd(1'h0);
  endtask : t_grst

  task automatic t_iface;
    lvds_select = 1'h1;
    repeat (5) @(posedge mclk);
    #2 check("lvds_mode", 12'h001, 12'(lvds_mode));
    check("lvds_lanes", 12'h000, 12'(serial_out_lane_enable));
    lvds_select = 1'h0;
    repeat (5) @(posedge mclk);
    #2 check("cmos_lanes", 12'h00f, 12'(serial_out_lane_enable));
  endtask : t_iface

  task automatic t_supply;
    load_span(12'h007);
    supply_ok = 1'h0;
    repeat (5) @(posedge mclk);
    #2 check("por_init", 12'h000, 12'(init_done));
    check("por_span", 12'hfff, span_select);
    supply_ok = 1'h1;
    wait_for(init_done, 1'h1);
    conv(104, 1'h0);
  endtask : t_supply

  task automatic wrap_up;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #300000;
    mismatches++;
    wrap_up();
  end

  initial begin
    rst_n = 1'h0;
    supply_ok = 1'h1;
    lvds_select = 1'h0;
    span_word_valid = 1'h0;
    span_word = 12'h000;
    mismatches = 0;
    samples_checked = 0;
    repeat (16) @(posedge mclk);
    #2 rst_n = 1'h1;
    t_reset_values();
    t_conv_full();
    t_span_disable();
    t_pd_mid();
    t_rearm();
    t_grst();
    t_iface();
    t_supply();
    wrap_up();
  end
endmodule : tb_top
